// File: hdl/mirror_array_power_sequencer.sv
`timescale 1ns/1ns
// How it works
// (R1) core and array-core supplies are enabled and seen good before any offset, bias or reset supply.
// (R2) bias and mirror-reset supplies come on a programmable delay (2 ms nominal, never below 1 ms) after offset is good.
// (R3) bias and mirror-reset supplies are switched together, no relative order needed.
// (R4) logic outputs to the array are forced low until core and array-core supplies are good.
// (R5) drive enable is released no sooner than 20 us after bias and reset supplies are good.
// (R6) shutdown waits for park done, then drops drive enable and switches off bias, reset and offset.
// (R7) loss of supply while running parks the mirrors at once and pulls drive enable low; before run it discharges without a park.
// (R8) core supplies stay on until bias, reset and offset good inputs show discharged.
// (R9) core supply stays on at least 50 us after the high supplies switch off.
// (R10) global bias command is a separate pulse issued once drive is enabled.
// (R11) all ordering lives here in the controller, never in the array device.
// (R12) each rail is judged from its own power-good input; a core, array-core, bias or reset drop while running forces emergency park.
// (R13) delays are counted in clock cycles from the clock rate, rounded up.
module mirror_array_power_sequencer #(
  parameter int unsigned CLK_FREQ_HZ = seq_pkg::CLK_HZ,
  parameter int unsigned OFFSET_TO_BIAS_DELAY_US = seq_pkg::OFFSET_TO_BIAS_DELAY_NOM_US
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_power_on,
  input wire logic i_power_fail,
  input wire logic [seq_pkg::NUM_RAILS-1:0] i_rail_good,
  input wire logic i_park_done,
  input wire logic [7:0] i_logic_out,
  output logic o_core_supply_en,
  output logic o_array_core_supply_en,
  output logic o_offset_supply_en,
  output logic o_bias_supply_en,
  output logic o_reset_supply_en,
  output logic o_mirror_drive_enable_n,
  output logic o_park_req,
  output logic o_emergency,
  output logic o_global_bias_cmd,
  output logic [7:0] o_logic_out,
  output logic o_ready
);
  import seq_pkg::*;
  // ==========================================================
  // delay counts
  localparam int unsigned DLY1_US = (OFFSET_TO_BIAS_DELAY_US < OFFSET_TO_BIAS_DELAY_MIN_US) ?
    OFFSET_TO_BIAS_DELAY_MIN_US : OFFSET_TO_BIAS_DELAY_US; // R2
  localparam logic [CNT_W-1:0] DLY1_CYC = us_to_cyc(CLK_FREQ_HZ, DLY1_US); // R13
  localparam logic [CNT_W-1:0] DLY2_CYC = us_to_cyc(CLK_FREQ_HZ, CORE_HOLD_DELAY_US); // R13
  localparam logic [CNT_W-1:0] DLY3_CYC = us_to_cyc(CLK_FREQ_HZ, BIAS_TO_ENABLE_DELAY_US); // R13
  // ==========================================================
  // input synchronisers
  logic [NUM_RAILS-1:0] good_m_r;
  logic [NUM_RAILS-1:0] good_r;
  logic [2:0] ctl_m_r;
  logic [2:0] ctl_r;
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      {good_r, good_m_r, ctl_r, ctl_m_r} <= '0;
    end
    else
    begin
      {good_r, good_m_r} <= {good_m_r, i_rail_good}; // R12
      {ctl_r, ctl_m_r} <= {ctl_m_r, i_park_done, i_power_fail, i_power_on};
    end
  end
  logic pwr_on;
  logic pwr_fail;
  logic park_done;
  logic core_good;
  logic high_good;
  logic high_discharged;
  assign pwr_on = ctl_r[0];
  assign pwr_fail = ctl_r[1];
  assign park_done = ctl_r[2];
  assign core_good = good_r[RAIL_CORE] && good_r[RAIL_ARRAY];
  assign high_good = good_r[RAIL_BIAS] && good_r[RAIL_RESET];
  assign high_discharged = !good_r[RAIL_OFFSET] && !good_r[RAIL_BIAS] && !good_r[RAIL_RESET];
  // ==========================================================
  // timer
  seq_timer_if tif ();
  seq_timer u_timer (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .t(tif.tmr)
  );
  // ==========================================================
  // state machine
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic load_nxt;
  logic [CNT_W-1:0] count_nxt;
  logic fault;
  // a lost core, array-core, bias or reset rail in ST_DLY3 or ST_RUN is treated as supply loss
  assign fault = pwr_fail || ((state_r == ST_RUN || state_r == ST_DLY3) && !(core_good && high_good)); // R7 R12
  always_comb
  begin
    state_nxt = state_r;
    load_nxt = 1'b0;
    count_nxt = '0;
    case (state_r)
      ST_OFF:
      begin
        if (pwr_on && !pwr_fail)
        begin
          state_nxt = ST_CORE;
        end
      end
      ST_CORE:
      begin
        if (pwr_fail || !pwr_on)
        begin
          state_nxt = ST_DOWN;
        end
        else if (core_good) // R1
        begin
          state_nxt = ST_OFFSET;
        end
      end
      ST_OFFSET:
      begin
        if (pwr_fail || !pwr_on)
        begin
          state_nxt = ST_DISCH;
        end
        else if (good_r[RAIL_OFFSET])
        begin
          state_nxt = ST_DLY1;
          load_nxt = 1'b1;
          count_nxt = DLY1_CYC; // R2
        end
      end
      ST_DLY1:
      begin
        if (pwr_fail || !pwr_on)
        begin
          state_nxt = ST_DISCH;
        end
        else if (tif.done)
        begin
          state_nxt = ST_BIAS;
        end
      end
      ST_BIAS:
      begin
        if (pwr_fail || !pwr_on)
        begin
          state_nxt = ST_DISCH;
        end
        else if (high_good)
        begin
          state_nxt = ST_DLY3;
          load_nxt = 1'b1;
          count_nxt = DLY3_CYC; // R5
        end
      end
      ST_DLY3:
      begin
        if (fault || !pwr_on)
        begin
          state_nxt = ST_DISCH;
        end
        else if (tif.done)
        begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (fault || !pwr_on)
        begin
          state_nxt = ST_PARK;
        end
      end
      ST_PARK:
      begin
        if (park_done) // R6
        begin
          state_nxt = ST_DISCH;
        end
      end
      ST_DISCH:
      begin
        load_nxt = 1'b1;
        count_nxt = DLY2_CYC; // R9
        state_nxt = ST_HOLD;
      end
      ST_HOLD:
      begin
        if (tif.done && high_discharged) // R8 R9
        begin
          state_nxt = ST_DOWN;
        end
      end
      ST_DOWN:
      begin
        if (!core_good && !pwr_on)
        begin
          state_nxt = ST_OFF;
        end
      end
      default:
      begin
        state_nxt = ST_DOWN;
      end
    endcase
  end
  assign tif.load = load_nxt;
  assign tif.count = count_nxt;
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      state_r <= ST_OFF;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end
  // ==========================================================
  // emergency flag, held until back off
  always_ff @(posedge i_mclk)
  begin
    if (i_srst || state_nxt == ST_OFF)
    begin
      o_emergency <= 1'b0;
    end
    else if (fault && state_r != ST_OFF)
    begin
      o_emergency <= 1'b1; // R7
    end
  end
  // ==========================================================
  // outputs, all registered from next state
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_core_supply_en <= 1'b0;
      o_array_core_supply_en <= 1'b0;
      o_offset_supply_en <= 1'b0;
      o_bias_supply_en <= 1'b0;
      o_reset_supply_en <= 1'b0;
      o_mirror_drive_enable_n <= 1'b0;
      o_park_req <= 1'b0;
      o_global_bias_cmd <= 1'b0;
      o_logic_out <= 8'h00;
      o_ready <= 1'b0;
    end
    else
    begin
      o_core_supply_en <= (state_nxt != ST_OFF) && (state_nxt != ST_DOWN); // R1 R8 R11
      o_array_core_supply_en <= (state_nxt != ST_OFF) && (state_nxt != ST_DOWN); // R1 R8
      o_offset_supply_en <= state_nxt inside {ST_OFFSET, ST_DLY1, ST_BIAS, ST_DLY3, ST_RUN, ST_PARK}; // R1 R6
      o_bias_supply_en <= state_nxt inside {ST_BIAS, ST_DLY3, ST_RUN, ST_PARK}; // R2 R3
      o_reset_supply_en <= state_nxt inside {ST_BIAS, ST_DLY3, ST_RUN, ST_PARK}; // R3
      // drive enable dropped at once on fault and kept low through the emergency park
      o_mirror_drive_enable_n <= (state_nxt == ST_RUN) || (state_nxt == ST_PARK && !fault && !o_emergency); // R5 R6 R7
      o_park_req <= (state_nxt == ST_PARK);
      o_global_bias_cmd <= (state_r == ST_DLY3) && (state_nxt == ST_RUN); // R10
      o_logic_out <= (core_good && state_nxt != ST_OFF && state_nxt != ST_DOWN) ? i_logic_out : 8'h00; // R4
      o_ready <= (state_nxt == ST_RUN);
    end
  end
  // ==========================================================
  // checks
  logic [CNT_W-1:0] hold_cnt_r;
  logic [CNT_W-1:0] off_cnt_r;
  logic [CNT_W-1:0] high_cnt_r;
  always_ff @(posedge i_mclk)
  begin
    hold_cnt_r <= (i_srst || o_offset_supply_en) ? '0 : hold_cnt_r + CNT_W'(hold_cnt_r != DLY2_CYC);
    off_cnt_r <= (i_srst || !good_r[RAIL_OFFSET]) ? '0 : off_cnt_r + CNT_W'(off_cnt_r != DLY1_CYC);
    high_cnt_r <= (i_srst || !high_good) ? '0 : high_cnt_r + CNT_W'(high_cnt_r != DLY3_CYC);
  end
  sequence s_high_on;
    $rose(o_bias_supply_en);
  endsequence
  a_core_first: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_offset_supply_en |-> (o_core_supply_en && o_array_core_supply_en)) else $error("offset before core"); // R1
  a_bias_after_offset: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_high_on |-> o_offset_supply_en && off_cnt_r == DLY1_CYC) else $error("bias too early"); // R2
  a_bias_reset_pair: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_bias_supply_en == o_reset_supply_en) else $error("bias and reset split"); // R3
  a_logic_low: assert property (@(posedge i_mclk) disable iff (i_srst)
    !o_core_supply_en |-> o_logic_out == 8'h00) else $error("logic driven unpowered"); // R4
  a_enable_after_high: assert property (@(posedge i_mclk) disable iff (i_srst)
    $rose(o_mirror_drive_enable_n) |-> high_cnt_r == DLY3_CYC && o_bias_supply_en) else $error("drive enable too early"); // R5
  a_enable_needs_high: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_mirror_drive_enable_n |-> o_bias_supply_en && o_offset_supply_en) else $error("drive on without high"); // R6
  a_fail_drops_enable: assert property (@(posedge i_mclk) disable iff (i_srst)
    (ctl_r[1] && o_mirror_drive_enable_n) |-> ##[1:2] !o_mirror_drive_enable_n) else $error("no emergency stop"); // R7
  a_core_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
    $fell(o_core_supply_en) |-> hold_cnt_r == DLY2_CYC) else $error("core dropped early"); // R9
  a_bias_cmd_once: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_global_bias_cmd |=> !o_global_bias_cmd && o_mirror_drive_enable_n) else $error("bias cmd bad"); // R10
endmodule : mirror_array_power_sequencer

// File: hdl/seq_pkg.sv
package seq_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned OFFSET_TO_BIAS_DELAY_NOM_US = 2000;
  localparam int unsigned OFFSET_TO_BIAS_DELAY_MIN_US = 1000;
  localparam int unsigned CORE_HOLD_DELAY_US = 50;
  localparam int unsigned BIAS_TO_ENABLE_DELAY_US = 20;
  localparam int unsigned CNT_W = 24;
  // ==========================================================
  // rail indices
  localparam int unsigned RAIL_CORE = 0;
  localparam int unsigned RAIL_ARRAY = 1;
  localparam int unsigned RAIL_OFFSET = 2;
  localparam int unsigned RAIL_BIAS = 3;
  localparam int unsigned RAIL_RESET = 4;
  localparam int unsigned NUM_RAILS = 5;
  // ==========================================================
  // states, gray along power-up path
  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_CORE = 4'h1,
    ST_OFFSET = 4'h3,
    ST_DLY1 = 4'h2,
    ST_BIAS = 4'h6,
    ST_DLY3 = 4'h7,
    ST_RUN = 4'h5,
    ST_PARK = 4'h4,
    ST_DISCH = 4'hC,
    ST_HOLD = 4'hD,
    ST_DOWN = 4'hF
  } seq_state_t;
  // cycles rounded up, at least one
  function automatic logic [CNT_W-1:0] us_to_cyc(input int unsigned hz, input int unsigned us);
    longint unsigned c;
    c = (longint'(hz) * longint'(us) + 64'd999999) / 64'd1000000;
    if (c == 0)
    begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction : us_to_cyc
endpackage : seq_pkg

// File: hdl/seq_timer_if.sv
`timescale 1ns/1ns
interface seq_timer_if;
  import seq_pkg::*;
  logic load;
  logic [CNT_W-1:0] count;
  logic done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : seq_timer_if

// File: hdl/seq_timer.sv
`timescale 1ns/1ns
module seq_timer (
  input wire logic i_mclk,
  input wire logic i_srst,
  seq_timer_if.tmr t
);
  import seq_pkg::*;
  logic [CNT_W-1:0] cnt_r;
  // ==========================================================
  // down counter, done high once count elapsed
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      cnt_r <= '0;
    end
    else if (t.load)
    begin
      cnt_r <= t.count;
    end
    else if (cnt_r != '0)
    begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  assign t.done = (cnt_r == '0) && !t.load;
endmodule : seq_timer

// File: sim/rail_model.sv
`timescale 1ns/1ns
// ==========================================================
// supply rails: good after a settle time, low after a discharge time
module rail_model #(
  parameter int SETTLE = 6,
  parameter int DISCH = 9
) (
  input wire logic i_mclk,
  input wire logic [4:0] i_en,
  input wire logic [4:0] i_drop,
  output logic [4:0] o_good
);
  int cnt_r [5];
  initial
  begin
    o_good = 5'h00;
    foreach (cnt_r[i]) cnt_r[i] = 0;
  end
  // one good flag per rail; a forced drop reads low at once
  always @(posedge i_mclk)
  begin
    for (int i = 0; i < 5; i++)
    begin
      cnt_r[i] <= (i_en[i] == o_good[i]) ? 0 : cnt_r[i] + 1;
      if (i_drop[i])
        o_good[i] <= 1'b0;
      else if (cnt_r[i] >= (i_en[i] ? SETTLE : DISCH))
        o_good[i] <= i_en[i];
    end
  end
endmodule : rail_model

// File: sim/mirror_array_power_sequencer_tb_top.sv
`timescale 1ns/1ns
module mirror_array_power_sequencer_tb_top;
  import seq_pkg::*;
  // delays at a 1 MHz count rate, offset delay at its 1 ms floor
  localparam int DLY1 = 1000;
  localparam int DLY2 = 50;
  localparam int DLY3 = 20;
  localparam int LIMIT = 20000;
  typedef struct packed {logic [7:0] din; logic [7:0] dexp;} row_t;
  row_t rows [4] = '{'{8'h00, 8'h00}, '{8'h5A, 8'h5A}, '{8'hA5, 8'hA5}, '{8'hFF, 8'hFF}};
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_power_on = 1'b0;
  logic i_power_fail = 1'b0;
  logic i_park_done = 1'b0;
  logic [7:0] i_logic_out = 8'h00;
  logic [4:0] drop = 5'h00;
  logic [NUM_RAILS-1:0] i_rail_good;
  logic core, arr, offs, bias, rst, den_n, park, emerg, gb, rdy;
  logic [7:0] o_logic_out;
  logic og_q, bg_q, off_q, bias_q, den_q, core_q;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int t_og = 0;
  int t_bg = 0;
  int t_hoff = 0;
  int n_gb = 0;
  always #20 i_mclk = ~i_mclk;
  mirror_array_power_sequencer #(.CLK_FREQ_HZ(1000000), .OFFSET_TO_BIAS_DELAY_US(1000)) DUT (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_power_on(i_power_on), .i_power_fail(i_power_fail),
    .i_rail_good(i_rail_good), .i_park_done(i_park_done), .i_logic_out(i_logic_out),
    .o_core_supply_en(core), .o_array_core_supply_en(arr), .o_offset_supply_en(offs),
    .o_bias_supply_en(bias), .o_reset_supply_en(rst), .o_mirror_drive_enable_n(den_n),
    .o_park_req(park), .o_emergency(emerg), .o_global_bias_cmd(gb), .o_logic_out(o_logic_out),
    .o_ready(rdy));
  rail_model rails (.i_mclk(i_mclk), .i_en({rst, bias, offs, arr, core}), .i_drop(drop), .o_good(i_rail_good));
  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic wait_for(input int sel, input int n);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < n; k++)
    begin
      @(negedge i_mclk);
      case (sel)
        0: hit = rdy;
        1: hit = park;
        2: hit = !core;
        3: hit = emerg;
        default: hit = offs;
      endcase
      if (hit === 1'b1)
        break;
    end
    check(hit, 1'b1);
  endtask : wait_for
  task automatic bring_up();
    int n0;
    n0 = n_gb;
    @(posedge i_mclk);
    i_logic_out <= 8'hFF;
    i_power_on <= 1'b1;
    wait_for(0, 3000);
    check(den_n, 1'b1);
    repeat (3) @(negedge i_mclk);
    check(n_gb - n0, 1);
  endtask : bring_up
  task automatic bring_down(input logic fault);
    @(posedge i_mclk);
    i_power_on <= 1'b0;
    wait_for(1, 20);
    // supplies must stay up while the park is outstanding
    repeat (30) @(negedge i_mclk);
    check({den_n, bias, offs}, {~fault, 2'b11});
    @(posedge i_mclk);
    i_park_done <= 1'b1;
    wait_for(2, 500);
    @(posedge i_mclk);
    i_park_done <= 1'b0;
    i_power_fail <= 1'b0;
    drop <= 5'h00;
    repeat (20) @(negedge i_mclk);
    check({emerg, rdy, core}, 3'b000);
  endtask : bring_down
  task automatic fault_run(input logic pf, input logic [4:0] d);
    bring_up();
    @(posedge i_mclk);
    i_power_fail <= pf;
    drop <= d;
    wait_for(3, 10);
    check(den_n, 1'b0);
    bring_down(1'b1);
  endtask : fault_run
  // ==========================================================
  // edge timing monitor, sampled mid-cycle
  always @(negedge i_mclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_fail++;
      test_done();
    end
    if (i_rail_good[2] && !og_q) t_og = cyc;
    if (&i_rail_good[4:3] && !bg_q) t_bg = cyc;
    if (offs && !off_q) check({arr, &i_rail_good[1:0]}, 2'b11);
    if (bias && !bias_q) check({rst, cyc - t_og >= DLY1}, 2'b11);
    if (den_n && !den_q) check(cyc - t_bg >= DLY3, 1'b1);
    if (!offs && off_q) t_hoff = cyc;
    if (!bias && bias_q) check({den_n, offs, rst}, 3'b000);
    if (!core && core_q)
    begin
      check(cyc - t_hoff >= DLY2, 1'b1);
      check(i_rail_good[4:2], 3'b000);
    end
    if (core && i_rail_good[1:0] != 2'b11) check(o_logic_out, 8'h00);
    if (gb === 1'b1) n_gb++;
    {og_q, bg_q, off_q, bias_q, den_q, core_q} = {i_rail_good[2], &i_rail_good[4:3], offs, bias, den_n, core};
  end
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge i_mclk);
    @(negedge i_mclk);
    check({core, arr, offs, bias, rst, den_n, park, emerg, gb, rdy, o_logic_out}, 0);
    @(posedge i_mclk);
    i_srst <= 1'b0;
    bring_up();
    foreach (rows[i])
    begin
      @(posedge i_mclk);
      i_logic_out <= rows[i].din;
      repeat (4) @(negedge i_mclk);
      check(o_logic_out, rows[i].dexp);
    end
    bring_down(1'b0);
    fault_run(1'b1, 5'h00);
    fault_run(1'b0, 5'h08);
    // supply loss during the offset wait skips the park and discharges at once
    @(posedge i_mclk);
    i_power_on <= 1'b1;
    wait_for(4, 100);
    @(posedge i_mclk);
    i_power_fail <= 1'b1;
    wait_for(3, 10);
    check({park, den_n, bias, offs}, 4'h0);
    @(posedge i_mclk);
    i_power_on <= 1'b0;
    wait_for(2, 500);
    @(posedge i_mclk);
    i_power_fail <= 1'b0;
    repeat (20) @(negedge i_mclk);
    check({emerg, core}, 2'b00);
    test_done();
  end
endmodule : mirror_array_power_sequencer_tb_top
